// ---- verilog/gp5_cfg.svh ----
/*
  Constants for the port 5 pin configuration block: register indices,
  byte addresses, field positions, write mask and reset values.
  Assumes it is included by bare name after the package.
*/
`ifndef GP5_CFG_SVH
`define GP5_CFG_SVH

// register indices as numbered on the pin configuration map
`define GP5_IDX_PIN52 10'h041
`define GP5_IDX_PIN53 10'h042
`define GP5_IDX_PIN54 10'h043
`define GP5_IDX_PIN55 10'h044
// byte address on the bus is four times the index
`define GP5_BYTE(idx) ({(idx), 2'b00})

// field positions inside one configuration byte
`define GP5_BIT_DIR 0
`define GP5_BIT_POL 1
`define GP5_BIT_FUNC_LO 2
`define GP5_BIT_FUNC_HI 3
`define GP5_BIT_OD 7

`define GP5_FUNC_GPIO 2'b00
`define GP5_FUNC_ALT 2'b01

// only direction, polarity, function and driver type are writable
`define GP5_WMASK 8'h8f

`define GP5_RST_PIN52 8'h01
`define GP5_RST_PIN53 8'h00
`define GP5_RST_PIN54 8'h01
`define GP5_RST_PIN55 8'h01

`endif

// ---- verilog/gp5_pkg.sv ----
/*
  Types shared by the port 5 pin configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gp5_pkg;

  typedef struct packed {
    logic od;
    logic [2:0] rsvd;
    logic [1:0] func;
    logic pol;
    logic dir_in;
  } gp5_cfg_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } gp5_pad_t;

endpackage

// ---- verilog/gp5_pin_cell.sv ----
/*
  One pin driver: direction, polarity, function select and driver type.
  Assumes the configuration byte and drive levels are synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gp5_cfg.svh"

module gp5_pin_cell #(
  parameter bit ALT_OUT = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration and internal levels
  input wire gp5_pkg::gp5_cfg_t cfg,
  input wire logic gpio_drive,
  input wire logic alt_drive,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic core_in
);
  import gp5_pkg::*;

  logic alt_sel;
  logic is_out;
  logic lvl;

  // reserved encodings 10 and 11 fall back to gpio
  assign alt_sel = (cfg.func == `GP5_FUNC_ALT);
  // alternate signals fix their own direction
  assign is_out = alt_sel ? ALT_OUT : ~cfg.dir_in;
  assign lvl = (alt_sel ? alt_drive : gpio_drive) ^ cfg.pol;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end else begin
      // open drain only ever pulls low
      pad_out <= cfg.od ? 1'b0 : lvl;
      pad_oe <= is_out & (cfg.od ? ~lvl : 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in <= 1'b0;
    end else begin
      core_in <= pad_in ^ cfg.pol;
    end
  end

  a_od_never_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    (presetn && cfg.od) |=> !pad_out)
    else $error("open drain pin driven high");

endmodule
`default_nettype wire

// ---- verilog/gp5_pin_config.sv ----
/*
  Port 5 pins 2..5 configuration registers on APB and their pin muxing.
  Assumes presetn is the standby power-on reset and that main power
  and hard reset arrive as synchronous pulses from an APB master.
*/
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "gp5_cfg.svh"

module gp5_pin_config #(
  parameter int ADDR_W = 12
) (
  // clock and standby power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // further resets, synchronous, active high
  input wire logic main_power_reset,
  input wire logic hard_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // gpio data side
  input wire logic [3:0] gpio_out_data,
  output logic [3:0] gpio_in_data,
  // second serial port side
  input wire logic serial2_transmit_data,
  input wire logic serial2_request_send_n,
  output logic serial2_receive_data,
  output logic serial2_set_ready_n,
  // pads 5.2 .. 5.5 on bits 0 .. 3
  input wire logic [3:0] pad_in,
  output gp5_pkg::gp5_pad_t pad
);
  import gp5_pkg::*;

  gp5_cfg_t cfg_reg [4];
  logic [31:0] prdata_reg;
  logic [2:0] dec;
  logic wr_en;
  logic [3:0] alt_drive;

  // {hit, index}; used by both the write and the read path
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] base;
    decode = 3'h0;
    for (int i = 0; i < 4; i++) begin
      base = ADDR_W'(`GP5_BYTE(`GP5_IDX_PIN52 + 10'(i)));
      if (a == base) begin
        decode = {1'b1, 2'(i)};
      end
    end
  endfunction

  function automatic logic [7:0] rst_val(input int i);
    case (i)
      0: rst_val = `GP5_RST_PIN52;
      1: rst_val = `GP5_RST_PIN53;
      2: rst_val = `GP5_RST_PIN54;
      default: rst_val = `GP5_RST_PIN55;
    endcase
  endfunction

  function automatic logic is_alt(input gp5_cfg_t c);
    is_alt = (c.func == `GP5_FUNC_ALT);
  endfunction

  assign dec = decode(paddr);
  // zero wait states: read data was captured in the setup cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~dec[2];
  assign prdata = prdata_reg;
  assign wr_en = psel & penable & pwrite & dec[2] & pstrb[0];

  // configuration registers
  for (genvar g = 0; g < 4; g++) begin : g_reg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_reg[g] <= rst_val(g);
      end else if ((g == 1) && (main_power_reset || hard_reset)) begin
        cfg_reg[g] <= `GP5_RST_PIN53;
      end else if (wr_en && (dec[1:0] == 2'(g))) begin
        cfg_reg[g] <= pwdata[7:0] & `GP5_WMASK;
      end
    end
  end

  // read capture; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable) begin
      prdata_reg <= dec[2] ? {24'h0, cfg_reg[dec[1:0]]} : 32'h0;
    end
  end

  // only pins 5.3 and 5.5 have an alternate output to drive
  assign alt_drive = {serial2_request_send_n, 1'b0,
                      serial2_transmit_data, 1'b0};

  for (genvar g = 0; g < 4; g++) begin : g_pin
    gp5_pin_cell #(.ALT_OUT(g[0])) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_reg[g]),
      .gpio_drive(gpio_out_data[g]),
      .alt_drive(alt_drive[g]),
      .pad_in(pad_in[g]),
      .pad_out(pad.out[g]),
      .pad_oe(pad.oe[g]),
      .core_in(gpio_in_data[g])
    );
  end

  // idle level given to the serial port when the pin is a gpio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial2_receive_data <= 1'b1;
      serial2_set_ready_n <= 1'b1;
    end else begin
      serial2_receive_data <= is_alt(cfg_reg[0]) ?
        (pad_in[0] ^ cfg_reg[0].pol) : 1'b1;
      serial2_set_ready_n <= is_alt(cfg_reg[2]) ?
        (pad_in[2] ^ cfg_reg[2].pol) : 1'b1;
    end
  end

  // all checks below run on the bus clock and sleep during reset
  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // presetn in antecedents keeps the release edge out of the checks
  a_dir_input_off: assert property (
    (presetn && cfg_reg[0].dir_in && !is_alt(cfg_reg[0])) |=>
    !pad.oe[0])
    else $error("input pin is driven");

  a_dir_input_55: assert property (
    (presetn && cfg_reg[3].dir_in && !is_alt(cfg_reg[3])) |=>
    !pad.oe[3])
    else $error("input pin 5.5 is driven");

  a_dir_output_on: assert property (
    (presetn && !cfg_reg[2].dir_in && !is_alt(cfg_reg[2]) &&
     !cfg_reg[2].od) |=> pad.oe[2])
    else $error("output pin not driven");

  a_pol_in_path: assert property (
    presetn |=>
    gpio_in_data[3] == ($past(pad_in[3]) ^ $past(cfg_reg[3].pol)))
    else $error("input polarity wrong");

  a_pol_out_path: assert property (
    (presetn && !is_alt(cfg_reg[2]) && !cfg_reg[2].dir_in &&
     !cfg_reg[2].od) |=>
    pad.out[2] == ($past(gpio_out_data[2]) ^ $past(cfg_reg[2].pol)))
    else $error("output polarity wrong");

  a_gpio_out_path: assert property (
    (presetn && !is_alt(cfg_reg[1]) && !cfg_reg[1].dir_in &&
     !cfg_reg[1].od) |=> (pad.oe[1] && pad.out[1] ==
     ($past(gpio_out_data[1]) ^ $past(cfg_reg[1].pol))))
    else $error("gpio output level wrong");

  a_rsvd_func_gpio: assert property (
    (presetn && cfg_reg[3].func[1] && cfg_reg[3].dir_in) |=>
    !pad.oe[3])
    else $error("reserved function not gpio");

  a_rx_route: assert property (
    (presetn && is_alt(cfg_reg[0])) |=> serial2_receive_data ==
      ($past(pad_in[0]) ^ $past(cfg_reg[0].pol)))
    else $error("receive data not routed");

  a_rx_idle: assert property (
    (presetn && !is_alt(cfg_reg[0])) |=>
    serial2_receive_data)
    else $error("receive data not idle");

  a_rx_no_drive: assert property (
    (presetn && is_alt(cfg_reg[0])) |=>
    !pad.oe[0])
    else $error("receive pin is driven");

  a_tx_route: assert property (
    (presetn && is_alt(cfg_reg[1]) && !cfg_reg[1].od) |=> (pad.oe[1] &&
     pad.out[1] == ($past(serial2_transmit_data) ^
                    $past(cfg_reg[1].pol))))
    else $error("transmit data not routed");

  a_tx_drives: assert property (
    (presetn && is_alt(cfg_reg[1]) && cfg_reg[1].dir_in &&
     !cfg_reg[1].od) |=> pad.oe[1])
    else $error("transmit pin not driven");

  a_dsr_idle: assert property (
    (presetn && !is_alt(cfg_reg[2])) |=>
    serial2_set_ready_n)
    else $error("set ready not idle");

  a_dsr_route: assert property (
    (presetn && is_alt(cfg_reg[2])) |=> serial2_set_ready_n ==
      ($past(pad_in[2]) ^ $past(cfg_reg[2].pol)))
    else $error("set ready not routed");

  a_dsr_no_drive: assert property (
    (presetn && is_alt(cfg_reg[2])) |=>
    !pad.oe[2])
    else $error("set ready pin is driven");

  a_rts_route: assert property (
    (presetn && is_alt(cfg_reg[3]) && !cfg_reg[3].od) |=> (pad.oe[3] &&
     pad.out[3] == ($past(serial2_request_send_n) ^
                    $past(cfg_reg[3].pol))))
    else $error("request send not routed");

  a_rts_drives: assert property (
    (presetn && is_alt(cfg_reg[3]) && cfg_reg[3].dir_in &&
     !cfg_reg[3].od) |=> pad.oe[3])
    else $error("request send pin not driven");

  a_od_release: assert property (
    (presetn && cfg_reg[1].od && !cfg_reg[1].dir_in &&
     !is_alt(cfg_reg[1])) |=>
    (pad.oe[1] == !($past(gpio_out_data[1]) ^ $past(cfg_reg[1].pol))))
    else $error("open drain enable wrong");

  a_od_pulls_low: assert property (
    (presetn && cfg_reg[3].od) |=>
    !pad.out[3])
    else $error("open drain pin 5.5 driven high");

  a_rsvd_zero: assert property (
    wr_en |=> (cfg_reg[0].rsvd == 3'h0 && cfg_reg[1].rsvd == 3'h0 &&
               cfg_reg[2].rsvd == 3'h0 && cfg_reg[3].rsvd == 3'h0))
    else $error("reserved bits stored");

  a_write_lands: assert property (
    (wr_en && dec[1:0] == 2'h0) |=>
    cfg_reg[0] == ($past(pwdata[7:0]) & `GP5_WMASK))
    else $error("write not stored");

  a_read_upper_zero: assert property (
    (psel && penable && !pwrite) |->
    prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  a_standby_defaults: assert property (
    $rose(presetn) |-> (cfg_reg[0] == `GP5_RST_PIN52 &&
      cfg_reg[2] == `GP5_RST_PIN54 && cfg_reg[3] == `GP5_RST_PIN55 &&
      cfg_reg[1] == `GP5_RST_PIN53))
    else $error("standby reset values wrong");

  a_main_keeps_52: assert property (
    ((main_power_reset || hard_reset) && !wr_en) |=>
    $stable(cfg_reg[0]))
    else $error("pin 5.2 lost on main reset");

  a_main_reset_53: assert property (
    (main_power_reset || hard_reset) |=>
    cfg_reg[1] == `GP5_RST_PIN53)
    else $error("pin 5.3 not reset");

  c_apb_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en);
  c_rx_alt: cover property (@(posedge pclk) disable iff (!presetn)
    is_alt(cfg_reg[0]) && !serial2_receive_data);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
  c_od_low: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[3].od && pad.oe[3]);

endmodule
`default_nettype wire

// ---- dv/gp5_board_model.sv ----
/*
  Board side of the port 5 pads: every pad the block leaves undriven
  takes a level chosen by the bench.
  Assumes pad.oe high means the block drives that pad.
*/
`timescale 1ns/10ps
`default_nettype none

module gp5_board_model (
  // pads from the block
  input wire gp5_pkg::gp5_pad_t pad,
  // far side levels
  input wire logic [3:0] ext_level,
  output logic [3:0] pad_in
);
  import gp5_pkg::*;
  // released pad shows the board level, never the last driven value
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & ext_level);
endmodule

`default_nettype wire

// ---- dv/gpio_pin_config_port5_tb.sv ----
/*
  Self-checking bench for the port 5 pin configuration block.
  Assumes the board model on the pads and a zero-wait APB slave.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gp5_cfg.svh"

module gpio_pin_config_port5_tb;
  import gp5_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, main_power_reset = 1'b0;
  logic hard_reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hf, gpio_out_data = 4'h0, ext_level = 4'hf;
  logic [3:0] gpio_in_data, pad_in;
  logic pready, pslverr, rx, dsr_n, slv, tx = 1'b1, rts_n = 1'b1;
  gp5_pad_t pad;
  logic [7:0] cfg_exp [4];
  int err_total = 0, checks_done = 0;

  always #2 pclk = ~pclk;

  gp5_pin_config u_gp5_pin_config (.pclk(pclk), .presetn(presetn),
    .main_power_reset(main_power_reset), .hard_reset(hard_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out_data(gpio_out_data),
    .gpio_in_data(gpio_in_data), .serial2_transmit_data(tx),
    .serial2_request_send_n(rts_n), .serial2_receive_data(rx),
    .serial2_set_ready_n(dsr_n), .pad_in(pad_in), .pad(pad));
  gp5_board_model u_gp5_board_model (.pad(pad), .ext_level(ext_level),
    .pad_in(pad_in));

  function automatic logic [11:0] addr(int i);
    return `GP5_BYTE(`GP5_IDX_PIN52 + 10'(i));
  endfunction

  // {oe, out} that pin i should show for configuration c
  function automatic logic [1:0] exp_drv(int i, logic [7:0] c);
    logic alt, lvl, is_out;
    alt = (c[3:2] == `GP5_FUNC_ALT);
    // alternate inputs 5.2 and 5.4 have no drive level of their own
    lvl = (alt ? (i == 1 ? tx : (i == 3 ? rts_n : 1'b0))
               : gpio_out_data[i]) ^ c[1];
    is_out = alt ? (i == 1 || i == 3) : !c[0];
    return c[7] ? {is_out & !lvl, 1'b0} : {is_out, lvl};
  endfunction

  task chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic w, input int i, input logic [7:0] d,
           input logic [3:0] s, input logic [11:0] a = 12'h000);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= (a != 12'h000) ? a : addr(i);
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task check_pins();
    logic [1:0] d;
    logic [3:0] pin;
    repeat (2) @(posedge pclk);
    #1;
    for (int i = 0; i < 4; i++) begin
      d = exp_drv(i, cfg_exp[i]);
      chk("pad oe", 32'(pad.oe[i]),
          32'(d[1]));
      chk("pad out", 32'(pad.out[i]),
          32'(d[0]));
      pin[i] = d[1] ? d[0] : ext_level[i];
      chk("gpio in", 32'(gpio_in_data[i]),
          32'(pin[i] ^ cfg_exp[i][1]));
    end
    chk("rx", 32'(rx), 32'(cfg_exp[0][3:2] == 2'b01 ?
        pin[0] ^ cfg_exp[0][1] : 1'b1));
    chk("dsr", 32'(dsr_n), 32'(cfg_exp[2][3:2] == 2'b01 ?
        pin[2] ^ cfg_exp[2][1] : 1'b1));
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is under 400 cycles; over a hundred times that means a hang
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    int i;
    logic [7:0] d;
    logic [3:0] s;
    void'($urandom(34));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cfg_exp = '{`GP5_RST_PIN52, `GP5_RST_PIN53, `GP5_RST_PIN54,
                `GP5_RST_PIN55};
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, k, 8'h00, 4'hf);
      chk("reset value", q, {24'h0, cfg_exp[k]});
    end
    check_pins();
    $display("test reset done");
    apb(1'b0, 0, 8'h00, 4'hf, 12'h114);
    chk("unmapped err", 32'(slv), 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("test unmapped done");
    // first four put each pin in alternate mode, open drain, reserved set
    for (int k = 0; k < 40; k++) begin
      i = k < 4 ? k : int'($urandom_range(3));
      d = k < 4 ? 8'hf5 : 8'($urandom);
      s = k < 4 ? 4'hf : 4'($urandom);
      apb(1'b1, i, d, s);
      if (s[0]) cfg_exp[i] = d & `GP5_WMASK;
      gpio_out_data <= 4'($urandom);
      ext_level <= 4'($urandom);
      tx <= 1'($urandom);
      rts_n <= 1'($urandom);
      check_pins();
      apb(1'b0, i, 8'h00, 4'hf);
      chk("cfg read", q, {24'h0, cfg_exp[i]});
      chk("mapped err", 32'(slv), 32'h0);
    end
    $display("test random done");
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, 1, 8'h8f, 4'hf);
      @(posedge pclk);
      main_power_reset <= (r == 0);
      hard_reset <= (r == 1);
      @(posedge pclk);
      main_power_reset <= 1'b0;
      hard_reset <= 1'b0;
      apb(1'b0, 1, 8'h00, 4'hf);
      chk("pin53 reset", q, 32'h0);
      apb(1'b0, 0, 8'h00, 4'hf);
      chk("pin52 kept", q, {24'h0, cfg_exp[0]});
    end
    $display("test power resets done");
    give_verdict();
  end
endmodule

`default_nettype wire
